// >>> verification/serial_master_model.sv
/* Behavioural external master: 48 ns serial clock, MSB first, type 1.
   Assumes the bench calls xfer for each 8-bit unit. */
`timescale 1ns/1ps
module serial_master_model (
  output logic sck_o,
  output logic si_o,
  input  wire  so_i
);
  initial begin
    sck_o = 1'b1;
    si_o = 1'b0;
  end
  // Calls may follow at once, so units run back to back
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_o = 1'b0;
      si_o = tx[i];
      #24;
      sck_o = 1'b1;
      rx[i] = so_i;
      #24;
    end
    // Clock stands high; a released line must not keep its last bit
    si_o = ~si_o;
  endtask
endmodule

// >>> verification/serial_port_unit_monitor.sv
/* Port checker for serial_port_unit.
   Assumes one clk_i domain; attached by the bind at the foot. */
`timescale 1ns/1ps
module serial_port_unit_monitor (
  input wire       clk_i,
  input wire       reset_i,
  input wire [7:0] ctrl_reg0_i,
  input wire [7:0] ctrl_reg1_i,
  input wire       tx_buffer_wr_i,
  input wire       overrun_clear_i,
  input wire       serial_clock_pin_o,
  input wire       serial_clock_pin_oe_o,
  input wire       serial_out_pin_o,
  input wire       xfer_in_progress_flag_o,
  input wire       overrun_flag_o,
  input wire       tx_enable_irq_o,
  input wire       rx_complete_irq_o,
  input wire       rx_error_irq_o
);
  wire pwr = ctrl_reg0_i[7];
  wire cont = ctrl_reg0_i[1];
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_flag_on_write: assert property (
    tx_buffer_wr_i && pwr && (cont || !xfer_in_progress_flag_o) |=> xfer_in_progress_flag_o)
    else $error("flag not set");
  a_tx_irq_pulse: assert property (
    tx_enable_irq_o |=> !tx_enable_irq_o) else $error("tx event too long");
  a_rc_irq_pulse: assert property (
    rx_complete_irq_o |=> !rx_complete_irq_o) else $error("rx event too long");
  a_err_needs_cont: assert property (
    rx_error_irq_o |-> cont && ctrl_reg0_i[5]) else $error("error outside continuous rx");
  a_err_sets_ovr: assert property (
    rx_error_irq_o |-> ##[0:2] overrun_flag_o) else $error("overrun flag not set");
  a_single_no_tx: assert property (
    !cont && !$past(cont) |-> !tx_enable_irq_o) else $error("tx event in single mode");
  a_ovr_holds: assert property (
    overrun_flag_o && !overrun_clear_i |=> overrun_flag_o) else $error("overrun lost");
  a_sck_idle: assert property (
    !pwr && !$past(pwr) && !$past(reset_i) && $stable(ctrl_reg1_i) |->
      ((ctrl_reg1_i[2:0] == 3'h7) ? !serial_clock_pin_oe_o :
       (serial_clock_pin_oe_o && serial_clock_pin_o == !ctrl_reg1_i[4])))
    else $error("clock pin idle wrong");
  a_so_low: assert property (
    !pwr && !$past(pwr) && $stable(ctrl_reg0_i) && $stable(ctrl_reg1_i) &&
      (!ctrl_reg0_i[6] || !ctrl_reg1_i[3]) |-> !serial_out_pin_o)
    else $error("data pin idle wrong");
endmodule

bind serial_port_unit serial_port_unit_monitor i_serial_port_unit_monitor (.*);

// >>> verification/test_serial_port_unit.sv
/* Self-checking bench for serial_port_unit with a behavioural master.
   Assumes design, checker and master model are compiled first. */
`timescale 1ns/1ps
module test_serial_port_unit;
  logic        clk_i, reset_i, tx_buffer_wr_i, flag_clear_i, overrun_clear_i, rx_read_i;
  logic [7:0]  ctrl_reg0_i, ctrl_reg1_i, r, t[5], s[5], m[5];
  logic [15:0] tx_buffer_i;
  wire         sck, si, so, ck_o, ck_oe, flag, ovr, rx_v, tx_irq, rc_irq, er_irq;
  wire  [15:0] rx_buf;
  int          fails = 0, checks_done = 0, n_tx = 0, n_rc = 0, n_er = 0, v, vt;
  serial_port_unit i_serial_port_unit (.clk_i(clk_i), .reset_i(reset_i),
    .ctrl_reg0_i(ctrl_reg0_i), .ctrl_reg1_i(ctrl_reg1_i), .length_ctrl_reg_i(4'h0),
    .tx_buffer_i(tx_buffer_i), .tx_buffer_wr_i(tx_buffer_wr_i), .flag_clear_i(flag_clear_i),
    .overrun_clear_i(overrun_clear_i), .rx_read_i(rx_read_i), .serial_clock_pin_i(sck),
    .serial_in_pin_i(si), .serial_clock_pin_o(ck_o), .serial_clock_pin_oe_o(ck_oe),
    .serial_out_pin_o(so), .xfer_in_progress_flag_o(flag), .overrun_flag_o(ovr),
    .rx_buffer_o(rx_buf), .rx_valid_o(rx_v), .tx_enable_irq_o(tx_irq),
    .rx_complete_irq_o(rc_irq), .rx_error_irq_o(er_irq));
  serial_master_model i_serial_master_model (.sck_o(sck), .si_o(si), .so_i(so));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    n_tx += (tx_irq === 1'b1);
    n_rc += (rc_irq === 1'b1);
    n_er += (er_irq === 1'b1);
  end
  function automatic logic [1:0] sck_idle(input logic [7:0] c1);
    return (c1[2:0] == 3'h7) ? 2'b00 : {1'b1, ~c1[4]};
  endfunction
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] d);
    @(posedge clk_i);
    tx_buffer_i <= {8'h00, d};
    tx_buffer_wr_i <= 1'b1;
    @(posedge clk_i);
    tx_buffer_wr_i <= 1'b0;
  endtask
  // Selector: 0 transfer flag clear, 1 overrun clear, 2 receive read
  task pulse(input int w);
    @(posedge clk_i);
    {rx_read_i, overrun_clear_i, flag_clear_i} <= 3'b001 << w;
    @(posedge clk_i);
    {rx_read_i, overrun_clear_i, flag_clear_i} <= 3'b000;
  endtask
  task automatic wait_more(ref int c, input int v0);
    repeat (400) if (c == v0) @(posedge clk_i);
    chk("event", 16'h1, 16'(c != v0));
  endtask
  task rd(input logic [7:0] e);
    #1;
    repeat (20) if (rx_v !== 1'b1) begin
      @(posedge clk_i);
      #1;
    end
    chk("rx_buffer", e, rx_buf[7:0]);
    pulse(2);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h169923cb));
    {reset_i, tx_buffer_wr_i, flag_clear_i, overrun_clear_i, rx_read_i} = 5'b10000;
    ctrl_reg0_i = 8'h01;
    ctrl_reg1_i = 8'h00;
    tx_buffer_i = 16'h0000;
    foreach (t[i]) begin
      t[i] = 8'($urandom);
      s[i] = 8'($urandom);
    end
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    ctrl_reg1_i <= 8'h07;
    ctrl_reg0_i <= 8'he3;
    wr(t[0]);
    #1 chk("flag", 1, flag);
    fork
      begin
        i_serial_master_model.xfer(s[0], m[0]);
        i_serial_master_model.xfer(s[1], m[1]);
      end
      begin
        wait_more(n_tx, n_tx);
        wr(t[1]);
        wait_more(n_rc, n_rc);
        rd(s[0]);
        wait_more(n_rc, n_rc);
        rd(s[1]);
      end
    join
    chk("tx0", t[0], m[0]);
    chk("tx1", t[1], m[1]);
    v = n_rc;
    i_serial_master_model.xfer(s[2], m[2]);
    wait_more(n_rc, v);
    rd(s[2]);
    pulse(0);
    #1 chk("flag", 0, flag);
    // Three units, none read: the second and third must each overrun
    wr(t[3]);
    v = n_er;
    for (int i = 2; i < 5; i++) i_serial_master_model.xfer(s[i], m[i]);
    repeat (20) @(posedge clk_i);
    chk("errors", 16'(v + 2), 16'(n_er));
    chk("overrun", 1, ovr);
    repeat (3) begin
      repeat (4) @(posedge clk_i);
      #1 if (rx_v === 1'b1) begin
        r = rx_buf[7:0];
        pulse(2);
      end
    end
    chk("newest", s[4], r);
    pulse(1);
    #1 chk("overrun", 0, ovr);
    pulse(0);
    @(posedge clk_i) ctrl_reg0_i <= 8'he1;
    wr(t[0]);
    wr(~t[0]);
    v = n_rc;
    vt = n_tx;
    i_serial_master_model.xfer(s[0], m[0]);
    wait_more(n_rc, v);
    chk("single", t[0], m[0]);
    chk("tx events", 16'(vt), 16'(n_tx));
    pulse(0);
    #1 chk("flag", 0, flag);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      ctrl_reg0_i <= {1'b0, 7'($urandom)};
      ctrl_reg1_i <= (i == 0) ? 8'h07 : 8'($urandom);
      repeat (3) @(posedge clk_i);
      #1 chk("sck", sck_idle(ctrl_reg1_i), {ck_oe, ck_o & ck_oe});
      if (!ctrl_reg0_i[6] || !ctrl_reg1_i[3]) chk("so", 0, so);
    end
    complete_run;
  end
endmodule

// >>> verilog/serial_port_map.vh
/*
  Constants for the clocked serial slave port: control field positions,
  encodings and reset values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH

`define CTRL0_PWR_BIT      7
`define CTRL0_TXE_BIT      6
`define CTRL0_RXE_BIT      5
`define CTRL0_DIR_BIT      4
`define CTRL0_SCE_BIT      2
`define CTRL0_CONT_BIT     1
`define CTRL0_START_BIT    0
`define CTRL0_RESET        8'h01
`define CTRL1_CKP_BIT      4
`define CTRL1_DAP_BIT      3
`define CTRL1_CKS_HI       2
`define CTRL1_CKS_LO       0
`define CTRL1_RESET        8'h00
`define CKS_EXTERNAL       3'h7
`define LEN_RESET          4'h0
`define LEN_BITS_DEFAULT   5'h08
`define LEN_BITS_BASE      5'h08
`define SYNC_STAGES        2
`define BUF_DEPTH          2

`endif

// >>> verilog/serial_port_unit.v
/*
  Clocked serial slave port with buffered transmit and receive, the
  transmit-enable, receive-complete and reception-error events, and the
  idle pin levels while powered down.
  Assumes an external master drives serial_clock_pin; control bits come
  from plain ports written by software logic on clk_i.
*/
// Contract
// - Clock select 111 means external-clock slave
// - Length field 0000 gives eight-bit units
// - Control word E3H enables full continuous operation
// - Transmit buffer write sets transfer flag
// - Drive output, sample input per serial clock
// - Buffer-to-shifter move raises transmit-enable event
// - Full unit received raises receive-complete, data readable
// - Reloaded buffer starts next unit back-to-back
// - Unit without reload still raises receive-complete
// - Unread receive buffer overrun raises error, flag
// - Overrun keeps the unread word in the receive buffer; newer words queue behind it until the two-entry buffer fills, then the newest replaces the waiting one
// - Error repeats each completion while still unread
// - Single mode: no transmit event, always complete
// - Single mode ignores writes while flag set
// - Powered-down clock pin idle per select, polarity
// - Clock pin level follows polarity and select
// - Powered-down output level per enable, phase, order
// - Output pin follows enable, order, phase changes
`timescale 1ns/1ps
`include "serial_port_map.vh"
module serial_port_unit (
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire [7:0]  ctrl_reg0_i,
  input  wire [7:0]  ctrl_reg1_i,
  input  wire [3:0]  length_ctrl_reg_i,
  input  wire [15:0] tx_buffer_i,
  input  wire        tx_buffer_wr_i,
  input  wire        flag_clear_i,
  input  wire        overrun_clear_i,
  input  wire        rx_read_i,
  input  wire        serial_clock_pin_i,
  input  wire        serial_in_pin_i,
  output reg         serial_clock_pin_o,
  output reg         serial_clock_pin_oe_o,
  output reg         serial_out_pin_o,
  output reg         xfer_in_progress_flag_o,
  output reg         overrun_flag_o,
  output reg  [15:0] rx_buffer_o,
  output reg         rx_valid_o,
  output reg         tx_enable_irq_o,
  output reg         rx_complete_irq_o,
  output reg         rx_error_irq_o
);
  // Control fields
  wire       power_enable  = ctrl_reg0_i[`CTRL0_PWR_BIT];
  wire       tx_enable     = ctrl_reg0_i[`CTRL0_TXE_BIT];
  wire       rx_enable     = ctrl_reg0_i[`CTRL0_RXE_BIT];
  wire       bit_order     = ctrl_reg0_i[`CTRL0_DIR_BIT];
  wire       continuous    = ctrl_reg0_i[`CTRL0_CONT_BIT];
  wire       clock_polarity = ctrl_reg1_i[`CTRL1_CKP_BIT];
  wire       data_phase    = ctrl_reg1_i[`CTRL1_DAP_BIT];
  wire [2:0] clock_select  = ctrl_reg1_i[`CTRL1_CKS_HI:`CTRL1_CKS_LO];
  wire       slave_mode    = (clock_select == `CKS_EXTERNAL);

  function [4:0] unit_bits;
    input [3:0] len;
    begin
      // Zero and values above eight select eight bits; 1..8 add to eight
      if (len == 4'h0 || len > 4'h8)
        unit_bits = `LEN_BITS_DEFAULT;
      else
        unit_bits = `LEN_BITS_BASE + {1'b0, len};
    end
  endfunction

  // Two-stage synchronisers: the first stage feeds only the second
  reg [1:0] sck_sync_q;
  reg [1:0] si_sync_q;
  reg       sck_prev_q;
  always @(posedge clk_i) begin
    if (reset_i) begin
      // Start at the clock pin's idle-high level so release makes no false edge
      sck_sync_q <= 2'b11;
      si_sync_q  <= 2'b00;
      sck_prev_q <= 1'b1;
    end else begin
      sck_sync_q <= {sck_sync_q[0], serial_clock_pin_i};
      si_sync_q  <= {si_sync_q[0], serial_in_pin_i};
      sck_prev_q <= sck_sync_q[1];
    end
  end
  wire sck_s   = sck_sync_q[1] ^ clock_polarity;
  wire sck_pv  = sck_prev_q ^ clock_polarity;
  wire lead_e  = sck_pv & ~sck_s;
  wire trail_e = ~sck_pv & sck_s;
  // Phase 0 shifts out on the lead edge and samples on the trail one (falling and rising at polarity 0)
  wire drive_e  = data_phase ? trail_e : lead_e;
  wire sample_e = data_phase ? lead_e : trail_e;
  wire run      = power_enable & slave_mode & (tx_enable | rx_enable);

  reg [15:0] tx_hold_q;
  reg        tx_full_q;
  reg [15:0] shift_q;
  reg        active_q;
  reg [4:0]  bit_cnt_q;
  reg        so_q;
  reg        unread_q;
  wire [4:0] nbits = unit_bits(length_ctrl_reg_i);
  wire [3:0] top   = nbits[3:0] - 4'h1;
  wire       wr_ok = tx_buffer_wr_i & (continuous | ~xfer_in_progress_flag_o);
  wire       last_sample = sample_e & active_q & (bit_cnt_q == nbits - 5'h1);

  // Received words pass the two-entry buffer; a stalled reader holds them
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [15:0] fifo_out_data;
  reg         push_q;
  reg  [15:0] push_data_q;
  wire        fifo_pop = fifo_out_valid & (~rx_valid_o | rx_read_i);

  two_entry_buffer rx_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (push_q),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_data_q),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data)
  );

  function [15:0] place_bit;
    input [15:0] word;
    input        b;
    input        lsb_first;
    input [3:0]  msb;
    reg   [15:0] t;
    begin
      t = word;
      if (lsb_first)
        place_bit = (t >> 1) | ({15'h0, b} << msb);
      else
        place_bit = {t[14:0], b};
    end
  endfunction

  function out_bit;
    input [15:0] word;
    input        lsb_first;
    input [3:0]  msb;
    begin
      out_bit = lsb_first ? word[0] : word[msb];
    end
  endfunction

  always @(posedge clk_i) begin
    if (reset_i) begin
      tx_hold_q               <= 16'h0000;
      tx_full_q               <= 1'b0;
      shift_q                 <= 16'h0000;
      active_q                <= 1'b0;
      bit_cnt_q               <= 5'h00;
      so_q                    <= 1'b0;
      unread_q                <= 1'b0;
      push_q                  <= 1'b0;
      push_data_q             <= 16'h0000;
      xfer_in_progress_flag_o <= 1'b0;
      overrun_flag_o          <= 1'b0;
      tx_enable_irq_o         <= 1'b0;
      rx_complete_irq_o       <= 1'b0;
      rx_error_irq_o          <= 1'b0;
    end else begin
      tx_enable_irq_o   <= 1'b0;
      rx_complete_irq_o <= 1'b0;
      rx_error_irq_o    <= 1'b0;
      if (fifo_in_ready)
        push_q <= 1'b0;
      if (wr_ok) begin
        tx_hold_q <= tx_buffer_i;
        tx_full_q <= 1'b1;
      end
      // Software clear loses to a new write in the same cycle
      if (wr_ok)
        xfer_in_progress_flag_o <= 1'b1;
      else if (flag_clear_i)
        xfer_in_progress_flag_o <= 1'b0;
      if (rx_read_i)
        unread_q <= 1'b0;
      if (overrun_clear_i)
        overrun_flag_o <= 1'b0;
      if (!run) begin
        active_q  <= 1'b0;
        bit_cnt_q <= 5'h00;
      end else if (xfer_in_progress_flag_o) begin
        // Continuous mode clocks a unit even without a reload, so receive still completes
        if (!active_q && (tx_full_q || !tx_enable || continuous) &&
            (drive_e || sample_e)) begin
          // Load shifter; phase 1 drives the first bit on the lead edge
          shift_q   <= tx_full_q ? tx_hold_q : 16'h0000;
          so_q      <= tx_enable & tx_full_q & out_bit(tx_hold_q, bit_order, top);
          tx_full_q <= wr_ok;
          active_q  <= 1'b1;
          bit_cnt_q <= 5'h00;
          if (continuous && tx_full_q)
            tx_enable_irq_o <= 1'b1;
        end
        if (active_q && drive_e && bit_cnt_q != 5'h00)
          so_q <= tx_enable & out_bit(shift_q, bit_order, top);
        if (sample_e && (active_q || data_phase == 1'b0)) begin
          shift_q   <= place_bit(shift_q, si_sync_q[1], bit_order, top);
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
        if (last_sample) begin
          active_q <= 1'b0;
          rx_complete_irq_o <= rx_enable | ~continuous;
          if (rx_enable) begin
            // Newest word replaces any word still waiting to enter the two-entry buffer
            push_q      <= 1'b1;
            push_data_q <= place_bit(shift_q, si_sync_q[1], bit_order, top);
            unread_q    <= 1'b1;
            if (continuous && unread_q && !rx_read_i) begin
              rx_error_irq_o <= 1'b1;
              overrun_flag_o <= 1'b1;
            end
          end
          // Continuous mode keeps the flag; single mode clears it, as writes are ignored while it is set
          if (!continuous)
            xfer_in_progress_flag_o <= wr_ok;
        end
      end
    end
  end

  // Receive buffer: holds its word while the reader stalls, then takes the next queued word
  always @(posedge clk_i) begin
    if (reset_i) begin
      rx_buffer_o <= 16'h0000;
      rx_valid_o  <= 1'b0;
    end else if (fifo_pop) begin
      rx_buffer_o <= fifo_out_data;
      rx_valid_o  <= 1'b1;
    end else if (rx_read_i) begin
      rx_valid_o  <= 1'b0;
    end
  end

  // Pin levels follow control bits within one cycle
  always @(posedge clk_i) begin
    if (reset_i) begin
      serial_clock_pin_o    <= 1'b1;
      serial_clock_pin_oe_o <= 1'b0;
      serial_out_pin_o      <= 1'b0;
    end else begin
      serial_clock_pin_o    <= ~clock_polarity;
      serial_clock_pin_oe_o <= ~slave_mode;
      if (!power_enable) begin
        if (!tx_enable)
          serial_out_pin_o <= 1'b0;
        else if (!data_phase)
          serial_out_pin_o <= so_q & 1'b0;
        else
          serial_out_pin_o <= out_bit(tx_hold_q, bit_order, top);
      end else begin
        serial_out_pin_o <= tx_enable & so_q;
      end
    end
  end
endmodule

// >>> verilog/two_entry_buffer.v
/*
  Two-entry valid/ready buffer for received words.
  Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module two_entry_buffer (
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire        in_valid_i,
  output wire        in_ready_o,
  input  wire [15:0] in_data_i,
  output wire        out_valid_o,
  input  wire        out_ready_i,
  output wire [15:0] out_data_o
);
  reg [15:0] mem_q [0:1];
  reg        wr_q;
  reg        rd_q;
  reg [1:0]  cnt_q;
  wire       push;
  wire       pop;

  assign in_ready_o  = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clk_i) begin
    if (reset_i) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data_i;
        wr_q        <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      if (push & ~pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule
